// >>> hw/mac_phy_defines.svh
// Constants for the MAC to PHY pin interface block.
// Assumes a 50 MHz system clock driving all logic.
`ifndef MAC_PHY_DEFINES_SVH
`define MAC_PHY_DEFINES_SVH

// System clock period
`define MAC_MCLK_NS 20
// Management clock minimum phase and period
`define MAC_MDC_MIN_PHASE_NS 160
`define MAC_MDC_MIN_PERIOD_NS 400
// Half period in clocks, rounded up, covering both minimums
`define MAC_MDC_HALF_NS ((`MAC_MDC_MIN_PERIOD_NS / 2) > `MAC_MDC_MIN_PHASE_NS ? \
  (`MAC_MDC_MIN_PERIOD_NS / 2) : `MAC_MDC_MIN_PHASE_NS)
`define MAC_MDC_HALF_CYC ((`MAC_MDC_HALF_NS + `MAC_MCLK_NS - 1) / `MAC_MCLK_NS)

// Transmit FIFO shape: nibble plus end-of-frame flag
`define MAC_FIFO_WIDTH 5
`define MAC_FIFO_DEPTH 8

// Management frame layout
`define MAC_MG_PREAMBLE 32'hFFFFFFFF
`define MAC_MG_START 2'h1
`define MAC_MG_OP_WRITE 2'h1
`define MAC_MG_OP_READ 2'h2
`define MAC_MG_TA_WRITE 2'h2
`define MAC_MG_TA_READ 2'h3
`define MAC_MG_IDLE_DATA 16'hFFFF
`define MAC_MG_HDR_BITS 6'h2E
`define MAC_MG_DATA_IDX 6'h30
`define MAC_MG_LAST_IDX 6'h3F

`endif

// >>> hw/mac_phy_pkg.sv
// Types for the MAC to PHY pin interface block.
// Assumes mac_phy_defines.svh holds all numeric constants.
package mac_phy_pkg;

  typedef enum logic [1:0] {
    MG_IDLE = 2'b00,
    MG_WAIT = 2'b01,
    MG_SHIFT = 2'b10
  } mgmt_state_t;

  typedef struct packed {
    logic tclk_s1;
    logic tclk_s2;
    logic tclk_d;
    logic rclk_s1;
    logic rclk_s2;
    logic rclk_d;
    logic [5:0] rx_s1;
    logic [5:0] rx_s2;
    logic crs_s1;
    logic crs_s2;
    logic col_s1;
    logic col_s2;
    logic mdi_s1;
    logic mdi_s2;
    logic tx_en;
    logic [3:0] txd;
    logic [3:0] tx_hold;
    logic [1:0] tx_bit;
    logic tx_last;
    logic rx_dv_d;
    logic [3:0] rx_shift;
    logic [1:0] rx_bit;
    logic rx_err_acc;
    logic rx_valid;
    logic [3:0] rx_data;
    logic rx_end;
    logic rx_err;
    logic carrier;
    logic collision;
    logic mdc;
    logic [3:0] mdc_div;
    mgmt_state_t mg_state;
    logic [63:0] mg_frame;
    logic [5:0] mg_idx;
    logic mg_read;
    logic mdio_out;
    logic mdio_oe;
    logic [15:0] mg_rdata;
    logic mg_done;
  } mac_state_t;

endpackage : mac_phy_pkg

// >>> hw/stream_fifo.sv
// Valid/ready FIFO held in flip-flops.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t n;
  logic push;
  logic pop;

  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wr] = in_data;
      n.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
    end
    if (pop) begin
      n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule : stream_fifo

// >>> hw/mac_phy_mii.sv
// MAC side of the MII / serial codec pin interface with management port.
// Assumes all PHY pins are asynchronous to mclk; config inputs are on mclk.
`timescale 1ns/100ps
`include "mac_phy_defines.svh"
module mac_phy_mii (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serial_codec_mode,
  input wire logic full_duplex,
  input wire logic tx_clk,
  output logic tx_en,
  output logic [3:0] txd,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd,
  input wire logic crs,
  input wire logic col,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic tx_nibble_valid,
  output logic tx_nibble_ready,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_nibble_last,
  output logic rx_nibble_valid,
  output logic [3:0] rx_nibble,
  output logic rx_frame_end,
  output logic rx_frame_err,
  output logic carrier,
  output logic collision,
  input wire logic mgmt_start,
  input wire logic mgmt_write,
  input wire logic [4:0] mgmt_phy,
  input wire logic [4:0] mgmt_reg,
  input wire logic [15:0] mgmt_wdata,
  output logic mgmt_busy,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_done
);

  mac_phy_pkg::mac_state_t s;
  mac_phy_pkg::mac_state_t n;
  logic fo_valid;
  logic [4:0] fo_data;
  logic tx_pop;
  logic t_rise;
  logic r_rise;
  logic rdv;
  logic mdc_tick;
  logic m_fall;
  logic m_rise;
  logic ser_more;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer

  stream_fifo #(
    .WIDTH(`MAC_FIFO_WIDTH),
    .DEPTH(`MAC_FIFO_DEPTH)
  ) tx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(tx_nibble_valid),
    .in_ready(tx_nibble_ready),
    .in_data({tx_nibble_last, tx_nibble}),
    .out_valid(fo_valid),
    .out_ready(tx_pop),
    .out_data(fo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge and event terms

  assign t_rise = s.tclk_s2 & ~s.tclk_d;
  assign r_rise = s.rclk_s2 & ~s.rclk_d;
  assign rdv = s.rx_s2[5];
  assign ser_more = s.tx_en & serial_codec_mode & (s.tx_bit != 2'h3);
  assign tx_pop = t_rise & fo_valid & ~ser_more & ~(s.tx_en & s.tx_last);
  assign mdc_tick = s.mdc_div == 4'(`MAC_MDC_HALF_CYC - 1);
  assign m_fall = mdc_tick & s.mdc;
  assign m_rise = mdc_tick & ~s.mdc;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    // Pin synchronisers
    n.tclk_s1 = tx_clk;
    n.tclk_s2 = s.tclk_s1;
    n.tclk_d = s.tclk_s2;
    n.rclk_s1 = rx_clk;
    n.rclk_s2 = s.rclk_s1;
    n.rclk_d = s.rclk_s2;
    n.rx_s1 = {rx_dv, rx_er, rxd};
    n.rx_s2 = s.rx_s1;
    n.crs_s1 = crs;
    n.crs_s2 = s.crs_s1;
    n.col_s1 = col;
    n.col_s2 = s.col_s1;
    n.mdi_s1 = mdio_in;
    n.mdi_s2 = s.mdi_s1;
    n.carrier = s.crs_s2;
    n.collision = s.col_s2 & ~full_duplex;

    // Transmit: one step per transmit clock rise
    if (t_rise) begin
      if (ser_more) begin
        n.tx_bit = s.tx_bit + 2'h1;
        n.txd = {3'h0, s.tx_hold[s.tx_bit + 2'h1]};
      end else if (s.tx_en && s.tx_last) begin
        n.tx_en = 1'b0;
        n.tx_last = 1'b0;
        n.txd = 4'h0;
      end else if (fo_valid) begin
        n.tx_en = 1'b1;
        n.tx_hold = fo_data[3:0];
        n.tx_last = fo_data[4];
        n.tx_bit = 2'h0;
        n.txd = serial_codec_mode ? {3'h0, fo_data[0]} : fo_data[3:0];
      end else begin
        n.tx_en = 1'b0;
        n.tx_last = 1'b0;
        n.txd = 4'h0;
      end
    end

    // Receive: sample on receive clock rise
    n.rx_valid = 1'b0;
    n.rx_end = 1'b0;
    if (r_rise) begin
      n.rx_dv_d = rdv;
      if (rdv) begin
        n.rx_err_acc = s.rx_err_acc | s.rx_s2[4];
        if (!serial_codec_mode) begin
          n.rx_valid = 1'b1;
          n.rx_data = s.rx_s2[3:0];
        end else begin
          n.rx_shift = {s.rx_s2[0], s.rx_shift[3:1]};
          n.rx_bit = s.rx_bit + 2'h1;
          if (s.rx_bit == 2'h3) begin
            n.rx_valid = 1'b1;
            n.rx_data = {s.rx_s2[0], s.rx_shift[3:1]};
          end
        end
      end else if (s.rx_dv_d) begin
        n.rx_end = 1'b1;
        n.rx_err = s.rx_err_acc;
        n.rx_err_acc = 1'b0;
        n.rx_bit = 2'h0;
      end
    end

    // Management clock divider
    if (mdc_tick) begin
      n.mdc_div = 4'h0;
      n.mdc = ~s.mdc;
    end else begin
      n.mdc_div = s.mdc_div + 4'h1;
    end

    // Management frame engine
    n.mg_done = 1'b0;
    case (s.mg_state)
      mac_phy_pkg::MG_IDLE: begin
        if (mgmt_start) begin
          n.mg_read = ~mgmt_write;
          n.mg_frame = {`MAC_MG_PREAMBLE, `MAC_MG_START,
                        mgmt_write ? `MAC_MG_OP_WRITE : `MAC_MG_OP_READ,
                        mgmt_phy, mgmt_reg,
                        mgmt_write ? `MAC_MG_TA_WRITE : `MAC_MG_TA_READ,
                        mgmt_write ? mgmt_wdata : `MAC_MG_IDLE_DATA};
          n.mg_state = mac_phy_pkg::MG_WAIT;
        end
      end
      mac_phy_pkg::MG_WAIT: begin
        if (m_fall) begin
          n.mdio_out = s.mg_frame[63];
          n.mdio_oe = 1'b1;
          n.mg_idx = 6'h0;
          n.mg_state = mac_phy_pkg::MG_SHIFT;
        end
      end
      mac_phy_pkg::MG_SHIFT: begin
        if (m_rise && s.mg_read && s.mg_idx >= `MAC_MG_DATA_IDX) begin
          n.mg_rdata = {s.mg_rdata[14:0], s.mdi_s2};
        end
        if (m_fall) begin
          if (s.mg_idx == `MAC_MG_LAST_IDX) begin
            n.mdio_oe = 1'b0;
            n.mdio_out = 1'b0;
            n.mg_done = 1'b1;
            n.mg_state = mac_phy_pkg::MG_IDLE;
          end else begin
            n.mg_idx = s.mg_idx + 6'h1;
            n.mg_frame = {s.mg_frame[62:0], 1'b0};
            n.mdio_out = s.mg_frame[62];
            n.mdio_oe = ~s.mg_read | ((s.mg_idx + 6'h1) < `MAC_MG_HDR_BITS);
          end
        end
      end
      default: begin
        n.mg_state = mac_phy_pkg::MG_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tx_en = s.tx_en;
  assign txd = s.txd;
  assign mdc = s.mdc;
  assign mdio_out = s.mdio_out;
  assign mdio_oe = s.mdio_oe;
  assign rx_nibble_valid = s.rx_valid;
  assign rx_nibble = s.rx_data;
  assign rx_frame_end = s.rx_end;
  assign rx_frame_err = s.rx_err;
  assign carrier = s.carrier;
  assign collision = s.collision;
  assign mgmt_busy = s.mg_state != mac_phy_pkg::MG_IDLE;
  assign mgmt_rdata = s.mg_rdata;
  assign mgmt_done = s.mg_done;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  tx_step_a: assert property ($changed(s.txd) |-> $past(t_rise))
    else $error("txd changed without a transmit clock rise");
  tx_one_a: assert property (tx_pop |=> s.tx_en && s.tx_hold == $past(fo_data[3:0]))
    else $error("popped nibble not placed on transmit");
  tx_serial_a: assert property (serial_codec_mode && s.tx_en |-> s.txd[3:1] == 3'h0)
    else $error("upper txd bits used in serial mode");
  tx_end_a: assert property (t_rise && s.tx_en && s.tx_last && !ser_more |=> !s.tx_en)
    else $error("tx_en held after last nibble");
  rx_err_a: assert property (r_rise && !rdv && !s.rx_dv_d |=> !s.rx_err_acc)
    else $error("receive error taken while rx_dv low");
  rx_take_a: assert property (s.rx_valid |-> $past(r_rise && rdv))
    else $error("nibble taken without rx_dv");
  rx_serial_a: assert property (serial_codec_mode && s.rx_valid |->
    $past(s.rx_bit) == 2'h3)
    else $error("serial nibble not four bits");
  crs_sync_a: assert property (##3 s.carrier == $past(crs, 3))
    else $error("carrier not three cycles behind pin");
  col_duplex_a: assert property (full_duplex |=> !s.collision)
    else $error("collision seen in full duplex");
  mdc_phase_a: assert property ($changed(s.mdc) |=> $stable(s.mdc) [*8])
    else $error("management clock phase too short");
  mdio_turn_a: assert property (s.mg_read && s.mg_state == mac_phy_pkg::MG_SHIFT
    && s.mg_idx >= `MAC_MG_HDR_BITS |-> !s.mdio_oe)
    else $error("MAC drives MDIO during read data");

endmodule : mac_phy_mii

// >>> test/phy_model.sv
// PHY stand-in: free-running link clocks, transmit capture, receive and mdio drive.
// Assumes the pins of mac_phy_mii are wired to it by name.
`timescale 1ns/100ps
module phy_model (
  output logic tx_clk,
  output logic rx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in
);
  logic [3:0] txq[$];
  int frames = 0;
  int bn = -1;
  logic prev_en = 1'b0;
  logic idle_er = 1'b0;
  logic rd = 1'b0;
  logic drv = 1'b0;
  logic drv_en = 1'b0;
  logic [63:0] cap = 64'h0;
  logic [15:0] rdv = 16'h3C96;
  ////////////////////////////////////////////////////////////////////////////
  // Link clocks, continuous, unrelated phase
  initial begin
    tx_clk = 1'b0;
    rx_dv = 1'b0;
    rx_er = 1'b0;
    rxd = 4'h0;
  end
  always #80 tx_clk = ~tx_clk;
  initial begin
    rx_clk = 1'b0;
    #37;
    forever #80 rx_clk = ~rx_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transmit capture, only enabled periods
  always @(posedge tx_clk) begin
    if (tx_en && !prev_en) frames++;
    if (tx_en) txq.push_back(txd);
    prev_en = tx_en;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Receive frame
  task rx_send(input logic [31:0] d, input int n, input int er_at, input logic ser);
    for (int i = 0; i < n; i++) begin
      @(negedge rx_clk);
      rx_dv = 1'b1;
      rx_er = (i == er_at);
      rxd = ser ? {3'b101, d[i]} : d[4*i+:4];
    end
    @(negedge rx_clk);
    rx_dv = 1'b0;
    rx_er = idle_er;
    rxd = ~rxd;
  endtask : rx_send
  ////////////////////////////////////////////////////////////////////////////
  // Management capture and read drive
  always @(posedge mdc) begin
    cap = {cap[62:0], mdio_in};
    if (bn >= 0) bn++;
    else if (mdio_oe) bn = 0;
    if (bn == 35) rd = (cap[1:0] == 2'h2);
    if (bn == 63) bn = -1;
  end
  always @(negedge mdc) begin
    drv_en = rd && bn >= 46 && bn < 63;
    drv = (bn >= 47) ? rdv[62-bn] : 1'b0;
  end
  // Wire level, pull-up when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);
endmodule : phy_model

// >>> test/tb_mac_phy_mii.sv
// Self-checking bench for mac_phy_mii.
// Assumes phy_model on the pins except crs and col; bench drives those, stream, config and mgmt ports.
`timescale 1ns/100ps
module tb_mac_phy_mii;
  logic mclk, rst_n, serial_codec_mode, full_duplex, crs, col;
  logic tx_clk, tx_en, rx_clk, rx_dv, rx_er, mdc, mdio_in, mdio_out, mdio_oe;
  logic [3:0] txd, rxd, tx_nibble, rx_nibble;
  logic tx_nibble_valid, tx_nibble_ready, tx_nibble_last, rx_nibble_valid;
  logic rx_frame_end, rx_frame_err, carrier, collision;
  logic mgmt_start, mgmt_write, mgmt_busy, mgmt_done;
  logic [4:0] mgmt_phy, mgmt_reg;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [3:0] rxq[$];
  logic full_seen, last_err, mdc_d;
  int fails = 0, checked = 0, ends = 0;
  int run = 0, lastrun = 0, ntr = 0, min_ph = 999, min_per = 999;
  ////////////////////////////////////////////////////////////////////////////
  mac_phy_mii u_dut (.mclk, .rst_n, .serial_codec_mode, .full_duplex, .tx_clk, .tx_en,
    .txd, .rx_clk, .rx_dv, .rx_er, .rxd, .crs, .col, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .tx_nibble_valid, .tx_nibble_ready, .tx_nibble, .tx_nibble_last, .rx_nibble_valid,
    .rx_nibble, .rx_frame_end, .rx_frame_err, .carrier, .collision, .mgmt_start,
    .mgmt_write, .mgmt_phy, .mgmt_reg, .mgmt_wdata, .mgmt_busy, .mgmt_rdata, .mgmt_done);
  phy_model u_phy (.tx_clk, .rx_clk, .tx_en, .txd, .rx_dv, .rx_er, .rxd, .mdc,
    .mdio_out, .mdio_oe, .mdio_in);
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  // Monitors
  always @(posedge mclk) begin
    if (rx_nibble_valid === 1'b1) rxq.push_back(rx_nibble);
    if (rx_frame_end === 1'b1) begin
      ends++;
      last_err = rx_frame_err;
    end
    if (rst_n && mdc === mdc_d) run++;
    else if (rst_n) begin
      if (ntr >= 2 && run < min_ph) min_ph = run;
      if (ntr >= 3 && run + lastrun < min_per) min_per = run + lastrun;
      ntr++;
      lastrun = run;
      run = 1;
      mdc_d = mdc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task report_and_stop;
    $display("Checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task push(input logic [3:0] n, input logic l);
    tx_nibble_valid <= 1'b1;
    tx_nibble <= n;
    tx_nibble_last <= l;
    @(posedge mclk);
    while (tx_nibble_ready !== 1'b1) begin
      full_seen = 1'b1;
      @(posedge mclk);
    end
  endtask : push
  task tx_wait(input int n);
    tx_nibble_valid <= 1'b0;
    for (int i = 0; i < 3000 && u_phy.txq.size() < n; i++) @(posedge mclk);
    chk("tx count", n, u_phy.txq.size());
  endtask : tx_wait
  task rx_wait(input int n);
    for (int i = 0; i < 500 && ends < n; i++) @(posedge mclk);
    chk("rx ends", n, ends);
  endtask : rx_wait
  task mg(input logic w, input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
    mgmt_start <= 1'b1;
    mgmt_write <= w;
    mgmt_phy <= p;
    mgmt_reg <= r;
    mgmt_wdata <= d;
    @(posedge mclk);
    mgmt_start <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("mg busy", 1, mgmt_busy);
    mgmt_start <= 1'b1;
    @(posedge mclk);
    mgmt_start <= 1'b0;
    for (int i = 0; i < 2000 && mgmt_done !== 1'b1; i++) @(posedge mclk);
    chk("mg done", 1, mgmt_done);
    chk("mg idle", 0, mgmt_busy);
  endtask : mg
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_tx_mii;
    u_phy.txq.delete();
    full_seen = 1'b0;
    for (int i = 0; i < 12; i++) push(i[3:0], i == 5 || i == 11);
    tx_wait(12);
    chk("tx frames", 2, u_phy.frames);
    chk("tx fifo full", 1, full_seen);
    for (int i = 0; i < 12; i++) chk("tx nibble", i, u_phy.txq[i]);
  endtask : t_tx_mii
  task t_tx_ser;
    repeat (10) @(posedge mclk);
    u_phy.txq.delete();
    serial_codec_mode <= 1'b1;
    push(4'hA, 1'b0);
    push(4'h5, 1'b1);
    tx_wait(8);
    for (int i = 0; i < 8; i++) chk("ser tx", {3'h0, 8'h5A >> i & 1}, u_phy.txq[i]);
  endtask : t_tx_ser
  task t_rx;
    serial_codec_mode <= 1'b0;
    u_phy.idle_er = 1'b1;
    u_phy.rx_er = 1'b1;
    u_phy.rx_send(32'h4B7, 3, -1, 1'b0);
    rx_wait(1);
    chk("rx err clean", 0, last_err);
    u_phy.rx_send(32'h21, 2, 1, 1'b0);
    rx_wait(2);
    chk("rx err flagged", 1, last_err);
    serial_codec_mode <= 1'b1;
    u_phy.idle_er = 1'b0;
    u_phy.rx_er = 1'b0;
    u_phy.rx_send(32'h6C, 8, -1, 1'b1);
    rx_wait(3);
    chk("rx frames", 3, ends);
    chk("rx nibbles", 28'h7B412C6,
      {rxq[0], rxq[1], rxq[2], rxq[3], rxq[4], rxq[5], rxq[6]});
  endtask : t_rx
  task t_crs;
    crs <= 1'b1;
    col <= 1'b1;
    @(posedge mclk);
    #1;
    chk("carrier early", 0, carrier);
    repeat (4) @(posedge mclk);
    #1;
    chk("carrier", 1, carrier);
    chk("collision", 1, collision);
    @(posedge mclk);
    full_duplex <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk("collision fdx", 0, collision);
    @(posedge mclk);
    col <= 1'b0;
    @(posedge mclk);
    crs <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk("carrier off", 0, carrier);
    @(posedge mclk);
  endtask : t_crs
  task t_mgmt;
    mg(1'b1, 5'h03, 5'h11, 16'hA5C3);
    chk("mg write", {32'hFFFFFFFF, 2'h1, 2'h1, 5'h03, 5'h11, 2'h2, 16'hA5C3},
      u_phy.cap);
    mg(1'b0, 5'h1E, 5'h07, 16'h0000);
    chk("mg read hdr", {32'hFFFFFFFF, 2'h1, 2'h2, 5'h1E, 5'h07}, u_phy.cap[63:18]);
    chk("mg read data", 16'h3C96, mgmt_rdata);
    chk("mdc timing", 1, min_ph >= 8 && min_per >= 20);
  endtask : t_mgmt
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    mdc_d = 1'b0;
    {serial_codec_mode, full_duplex, crs, col, mgmt_start, mgmt_write} = 6'h00;
    {tx_nibble_valid, tx_nibble, tx_nibble_last} = 6'h00;
    {mgmt_phy, mgmt_reg, mgmt_wdata} = 26'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_tx_mii;
    t_tx_ser;
    t_rx;
    t_crs;
    t_mgmt;
    report_and_stop;
  end
  initial begin
    #1000000;
    fails++;
    report_and_stop;
  end
endmodule : tb_mac_phy_mii
